// ---- hw/dl_sched_params.svh ----
// constants for the download schedule and fragment decoder
`ifndef DL_SCHED_PARAMS_SVH
`define DL_SCHED_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DLS_OFF_CTRL 8'h00
`define DLS_OFF_POLL 8'h04
`define DLS_OFF_TIME 8'h08
`define DLS_OFF_STAT 8'h0c
`define DLS_OFF_RELT 8'h10

// ----------------------------------------
// control register fields and resets
// ----------------------------------------
`define DLS_CTRL_EN 0
`define DLS_CTRL_ALT 1
`define DLS_CTRL_RST 2'h1
`define DLS_POLL_RST 8'h04
`define DLS_TIME_RST 24'h000000

// ----------------------------------------
// descriptor entry fields
// ----------------------------------------
`define DLS_TIME_MSB 23
`define DLS_TVALID_BIT 29
`define DLS_PRESET_BIT 28
`define DLS_LEN_MSB 12
`define DLS_LAST_BIT 31
`define DLS_ENTRY_STEP 32'h00000004

// ----------------------------------------
// timing
// ----------------------------------------
`define DLS_CLK_PS 4000
`define DLS_TICK_NS 800
`define DLS_TICK_CYC ((`DLS_TICK_NS * 1000 + `DLS_CLK_PS - 1) / `DLS_CLK_PS)

`endif

// ---- hw/dl_sched_pkg.sv ----
// types shared by the download schedule and fragment decoder
package dl_sched_pkg;

  // engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FETCH_SCHED,
    ST_WAIT_SCHED,
    ST_POLL_WAIT,
    ST_FETCH_ADDR,
    ST_WAIT_ADDR,
    ST_FETCH_LEN,
    ST_WAIT_LEN,
    ST_XFER_REQ,
    ST_XFER_WAIT,
    ST_DONE
  } dl_state_e;

endpackage

// ---- hw/tick_div.sv ----
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
`default_nettype none

module tick_div #(
  parameter int DIV = 200
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // enable pulse
  output logic o_tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_r;
  wire wrap = (cnt_r == CW'(DIV - 1));

  // free running count, pulse on wrap
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + CW'(1);
      o_tick <= wrap;
    end
  end

endmodule

`default_nettype wire

// ---- hw/dl_sched.sv ----
// download schedule and fragment decoder of the transmit engine
//
// Summary of operation
// - timed entry low 24 bits are release time or counter preset value
// - time-valid set, preset clear: download once counter exceeds release time
// - while not due, poll: refetch timed entry every poll interval, compare again
// - running time counter advances once every 800 ns
// - preset flag copies time field into counter, download at once
// - preset flag wins; time-valid ignored, no comparison made
// - both flags clear: time field ignored, download immediately
// - alternate sequence mode has no timed entry; engine skips it
// - fragment address is full 32-bit byte address, any alignment
// - length entry follows its address entry and applies to that block
// - byte count is length entry bits 12:0, exactly that many moved
// - top bit of length entry marks final fragment, ends the packet
//
// limitations:
// one host read outstanding; each o_rd_req expects exactly one i_rd_valid
// release compare is plain unsigned, so a wrapped counter looks early
// alternate sequence mode is sampled once, when the packet starts
// entry preset wins over a software counter write in the same cycle
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "dl_sched_params.svh"

module dl_sched
  import dl_sched_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // packet start
  input wire logic i_start,
  input wire logic [31:0] i_desc_addr,
  output logic o_busy,
  output logic o_done,
  output logic o_polling,
  // host memory entry reads
  output logic o_rd_req,
  output logic [31:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  // fragment data transfer
  output logic o_xfer_req,
  output logic [31:0] o_xfer_addr,
  output logic [12:0] o_xfer_len,
  input wire logic i_xfer_done
);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  // sequencer state and software settings
  dl_state_e state_r, state_nxt;
  logic [1:0] ctrl_r;
  logic [7:0] poll_r;
  // time base and the release value last read
  logic [23:0] running_time_counter_r, running_time_counter_nxt;
  logic [23:0] release_time_r, release_time_nxt;
  // poll progress and descriptor walk
  logic [7:0] poll_cnt_r, poll_cnt_nxt;
  logic [31:0] sched_addr_r, sched_addr_nxt;
  logic [31:0] ptr_r, ptr_nxt;
  logic [31:0] frag_addr_r, frag_addr_nxt;
  logic [12:0] frag_len_r, frag_len_nxt;
  logic last_r, last_nxt;
  // next values of the registered outputs
  logic rd_req_nxt, xfer_req_nxt, done_nxt;
  logic [31:0] rd_addr_nxt;
  logic tick;

  // ----------------------------------------
  // 800 ns time base
  // ----------------------------------------
  // free running; a counter write does not realign the tick phase
  tick_div #(
    .DIV(`DLS_TICK_CYC)
  ) u_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_tick(tick)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // reads have no side effects, so any offset may be polled
  wire sel_ctrl = (i_reg_addr == `DLS_OFF_CTRL);
  wire sel_poll = (i_reg_addr == `DLS_OFF_POLL);
  wire sel_time = (i_reg_addr == `DLS_OFF_TIME);
  wire sel_stat = (i_reg_addr == `DLS_OFF_STAT);
  wire sel_relt = (i_reg_addr == `DLS_OFF_RELT);
  wire wr_ctrl = i_reg_wr && sel_ctrl;
  wire wr_poll = i_reg_wr && sel_poll;
  wire wr_time = i_reg_wr && sel_time;
  wire eng_en = ctrl_r[`DLS_CTRL_EN];
  wire alt_mode = ctrl_r[`DLS_CTRL_ALT];
  wire [31:0] stat_word = {26'h0000000, o_polling, o_busy, state_r};

  // read mux; unmapped offsets answer zero
  wire [31:0] rd_mux =
    sel_ctrl ? {30'h00000000, ctrl_r} :
    sel_poll ? {24'h000000, poll_r} :
    sel_time ? {8'h00, running_time_counter_r} :
    sel_stat ? stat_word :
    sel_relt ? {8'h00, release_time_r} : 32'h00000000;

  // ----------------------------------------
  // timed entry decode
  // ----------------------------------------
  // flags taken straight off the returned word, never stored
  wire [23:0] entry_time = i_rd_data[`DLS_TIME_MSB:0];
  wire entry_valid = i_rd_data[`DLS_TVALID_BIT];
  wire entry_preset = i_rd_data[`DLS_PRESET_BIT];
  // strict compare: equal is still early
  wire entry_due = running_time_counter_r > entry_time;
  // count runs up to the poll setting, so n waits n+1 ticks
  wire poll_over = (poll_cnt_r >= poll_r);

  // ----------------------------------------
  // fragment entry decode
  // ----------------------------------------
  // a zero count is legal and moves no data
  wire [12:0] entry_len = i_rd_data[`DLS_LEN_MSB:0];
  wire entry_last = i_rd_data[`DLS_LAST_BIT];
  wire [31:0] ptr_step = ptr_r + `DLS_ENTRY_STEP;

  // ----------------------------------------
  // engine sequencing
  // ----------------------------------------
  // walks one descriptor: timed entry, then address and length pairs
  // fetch and wait states alternate, so a request never overlaps a reply
  always_comb begin
    state_nxt = state_r;
    release_time_nxt = release_time_r;
    poll_cnt_nxt = poll_cnt_r;
    sched_addr_nxt = sched_addr_r;
    ptr_nxt = ptr_r;
    frag_addr_nxt = frag_addr_r;
    frag_len_nxt = frag_len_r;
    last_nxt = last_r;
    rd_req_nxt = 1'b0;
    rd_addr_nxt = o_rd_addr;
    xfer_req_nxt = 1'b0;
    done_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (i_start && eng_en) begin
          sched_addr_nxt = i_desc_addr;
          ptr_nxt = i_desc_addr;
          // no timed entry in the alternate sequence
          state_nxt = alt_mode ? ST_FETCH_ADDR : ST_FETCH_SCHED;
        end
      end
      ST_FETCH_SCHED: begin
        // each poll refetches the same entry, driver may edit it
        rd_req_nxt = 1'b1;
        rd_addr_nxt = sched_addr_r;
        state_nxt = ST_WAIT_SCHED;
      end
      ST_WAIT_SCHED: begin
        if (i_rd_valid) begin
          release_time_nxt = entry_time;
          ptr_nxt = sched_addr_r + `DLS_ENTRY_STEP;
          poll_cnt_nxt = 8'h00;
          if (entry_preset) begin
            state_nxt = ST_FETCH_ADDR;
          end else if (entry_valid && !entry_due) begin
            state_nxt = ST_POLL_WAIT;
          end else begin
            state_nxt = ST_FETCH_ADDR;
          end
        end
      end
      ST_POLL_WAIT: begin
        // interval counted in 800 ns ticks
        if (tick) begin
          if (poll_over) begin
            state_nxt = ST_FETCH_SCHED;
          end else begin
            poll_cnt_nxt = poll_cnt_r + 8'h01;
          end
        end
      end
      ST_FETCH_ADDR: begin
        rd_req_nxt = 1'b1;
        rd_addr_nxt = ptr_r;
        state_nxt = ST_WAIT_ADDR;
      end
      ST_WAIT_ADDR: begin
        if (i_rd_valid) begin
          // kept whole, no alignment forced
          frag_addr_nxt = i_rd_data;
          ptr_nxt = ptr_step;
          state_nxt = ST_FETCH_LEN;
        end
      end
      ST_FETCH_LEN: begin
        // length entry is the word right after its address
        rd_req_nxt = 1'b1;
        rd_addr_nxt = ptr_r;
        state_nxt = ST_WAIT_LEN;
      end
      ST_WAIT_LEN: begin
        if (i_rd_valid) begin
          frag_len_nxt = entry_len;
          last_nxt = entry_last;
          ptr_nxt = ptr_step;
          if (entry_len != 13'h0000) begin
            state_nxt = ST_XFER_REQ;
          end else begin
            // empty fragment moves nothing
            state_nxt = entry_last ? ST_DONE : ST_FETCH_ADDR;
          end
        end
      end
      ST_XFER_REQ: begin
        xfer_req_nxt = 1'b1;
        state_nxt = ST_XFER_WAIT;
      end
      ST_XFER_WAIT: begin
        // address and count stay on the outputs until the next pair
        if (i_xfer_done) begin
          state_nxt = last_r ? ST_DONE : ST_FETCH_ADDR;
        end
      end
      ST_DONE: begin
        // one-cycle end pulse, then back to idle
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // running time counter
  // ----------------------------------------
  // entry preset beats a software write in the same cycle
  wire entry_load = (state_r == ST_WAIT_SCHED) && i_rd_valid && entry_preset;

  // one source per cycle: entry preset, software write, then tick
  always_comb begin
    if (entry_load) begin
      running_time_counter_nxt = entry_time;
    end else if (wr_time) begin
      running_time_counter_nxt = i_reg_wdata[23:0];
    end else if (tick) begin
      // wraps at 24 bits like the release field
      running_time_counter_nxt = running_time_counter_r + 24'h000001;
    end else begin
      running_time_counter_nxt = running_time_counter_r;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // status and release value have no write path, writes there are dropped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `DLS_CTRL_RST;
      poll_r <= `DLS_POLL_RST;
      o_reg_rdata <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= i_reg_wdata[1:0];
      end
      if (wr_poll) begin
        poll_r <= i_reg_wdata[7:0];
      end
      // data only in the cycle after the strobe
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // engine state flops
  // ----------------------------------------
  // whole walk restarts from idle on reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      running_time_counter_r <= `DLS_TIME_RST;
      release_time_r <= 24'h000000;
      poll_cnt_r <= 8'h00;
      sched_addr_r <= 32'h00000000;
      ptr_r <= 32'h00000000;
      frag_addr_r <= 32'h00000000;
      frag_len_r <= 13'h0000;
      last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      running_time_counter_r <= running_time_counter_nxt;
      release_time_r <= release_time_nxt;
      poll_cnt_r <= poll_cnt_nxt;
      sched_addr_r <= sched_addr_nxt;
      ptr_r <= ptr_nxt;
      frag_addr_r <= frag_addr_nxt;
      frag_len_r <= frag_len_nxt;
      last_r <= last_nxt;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // driven from next values so each output is a plain flop
  // busy and polling follow the state being entered
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_req <= 1'b0;
      o_rd_addr <= 32'h00000000;
      o_xfer_req <= 1'b0;
      o_xfer_addr <= 32'h00000000;
      o_xfer_len <= 13'h0000;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_polling <= 1'b0;
    end else begin
      o_rd_req <= rd_req_nxt;
      o_rd_addr <= rd_addr_nxt;
      o_xfer_req <= xfer_req_nxt;
      o_xfer_addr <= frag_addr_nxt;
      o_xfer_len <= frag_len_nxt;
      o_done <= done_nxt;
      o_busy <= (state_nxt != ST_IDLE);
      o_polling <= (state_nxt == ST_POLL_WAIT);
    end
  end

endmodule

`default_nettype wire

// ---- test/dl_sched_checker.sv ----
// port assertions for the download schedule decoder
`timescale 1ns/10ps
`default_nettype none
module dl_sched_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // watched outputs
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_polling,
  input wire logic o_rd_req,
  input wire logic o_xfer_req,
  input wire logic [31:0] o_xfer_addr,
  input wire logic [12:0] o_xfer_len
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // first entry fetch one cycle after busy rises
  property p_first_fetch; $rose(o_busy) |=> o_rd_req; endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("no entry fetch");
  // one outstanding read, so requests are single pulses
  property p_req_pulse; o_rd_req |=> !o_rd_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("read held");
  // nothing is moved while waiting to poll
  property p_poll_hold; o_polling |-> o_busy && !o_xfer_req; endproperty
  a_poll_hold: assert property (p_poll_hold) else $error("move in poll");
  // packet end drops busy and lasts one cycle
  property p_done_end; o_done |-> !o_busy ##1 !o_done; endproperty
  a_done_end: assert property (p_done_end) else $error("bad done");
  // zero counts never start a move
  property p_xfer_len; o_xfer_req |-> o_busy && o_xfer_len != 13'h0; endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("empty move");
  // block address and count hold in the cycle after the move request
  property p_xfer_hold;
    o_xfer_req |=> $stable(o_xfer_addr) && $stable(o_xfer_len);
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("move changed");
  // a length read never overlaps the move it governs
  property p_one_op; o_xfer_req |-> !o_rd_req ##1 !o_xfer_req; endproperty
  a_one_op: assert property (p_one_op) else $error("overlap");
  // busy only falls at packet end
  property p_done_fall; $fell(o_busy) |-> o_done; endproperty
  a_done_fall: assert property (p_done_fall) else $error("silent end");
  // a poll always ends in a refetch of the timed entry
  property p_poll_refetch; $fell(o_polling) |=> o_rd_req; endproperty
  a_poll_refetch: assert property (p_poll_refetch) else $error("poll without refetch");
  // main scenarios reached
  c_poll: cover property (o_polling);
  c_done: cover property (o_done);
  c_max: cover property (o_xfer_req && o_xfer_len == 13'h1fff);
endmodule
bind dl_sched dl_sched_checker chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .o_busy(o_busy), .o_done(o_done),
  .o_polling(o_polling), .o_rd_req(o_rd_req), .o_xfer_req(o_xfer_req),
  .o_xfer_addr(o_xfer_addr), .o_xfer_len(o_xfer_len)
);
`default_nettype wire

// ---- test/host_mem.sv ----
// host memory model holding descriptor entries and taking data moves
`timescale 1ns/10ps
`default_nettype none
module host_mem (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // entry reads
  input wire logic i_rd_req,
  input wire logic [31:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  // data moves
  input wire logic i_xfer_req,
  input wire logic [31:0] i_xfer_addr,
  input wire logic [12:0] i_xfer_len,
  output logic o_xfer_done
);
  logic [31:0] mem [8];
  int lat = 1;
  int cnt = 0;
  int xc = 0;
  int nx = 0;
  int sum = 0;
  logic [31:0] last_a = 32'h0;
  // answer after lat cycles; data toggles when not valid so stale values never match
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'h0;
      o_rd_data <= 32'h0;
      o_xfer_done <= 1'h0;
      cnt <= 0;
      xc <= 0;
    end else begin
      o_rd_valid <= 1'h0;
      o_xfer_done <= 1'h0;
      o_rd_data <= ~o_rd_data;
      if (i_rd_req) begin
        cnt <= lat;
      end else if (cnt == 1) begin
        o_rd_valid <= 1'h1;
        o_rd_data <= mem[i_rd_addr[4:2]];
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      // moves are recorded to judge address and count later
      if (i_xfer_req) begin
        xc <= lat + 1;
        nx <= nx + 1;
        sum <= sum + int'(i_xfer_len);
        last_a <= i_xfer_addr;
      end else if (xc == 1) begin
        o_xfer_done <= 1'h1;
        xc <= 0;
      end else if (xc > 1) begin
        xc <= xc - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the download schedule decoder
`timescale 1ns/10ps
`default_nettype none
`include "dl_sched_params.svh"
module testbench import dl_sched_pkg::*;;
  logic i_clk = 1'h0, i_rstn = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_start = 1'h0;
  logic [7:0] i_reg_addr = 8'h0;
  logic [31:0] i_reg_wdata = 32'h0, i_desc_addr = 32'h0, o_reg_rdata, o_rd_addr, rd_data;
  logic [31:0] o_xfer_addr, v;
  logic o_busy, o_done, o_polling, o_rd_req, rd_valid, o_xfer_req, xfer_done;
  logic [12:0] o_xfer_len;
  int fails = 0, checks_done = 0, n0, s0, p0, poll_cyc = 0;
  typedef struct {logic [23:0] tw; logic [31:0] te; logic pl; logic [31:0] fa;
    logic [12:0] l1, l2;} row_s;
  // counter preset, timed entry, poll expected, block address, two counts
  row_s rows [5] = '{
    '{24'h000010, 32'h00000123, 1'h0, 32'h10000001, 13'h0003, 13'h1fff},
    '{24'h000010, 32'h30000500, 1'h0, 32'h20000002, 13'h0001, 13'h0005},
    '{24'h000800, 32'h20000100, 1'h0, 32'h30000003, 13'h0100, 13'h0002},
    '{24'h000900, 32'h20000902, 1'h1, 32'h40000000, 13'h0007, 13'h0001},
    '{24'h000a00, 32'h20000a00, 1'h1, 32'h50000005, 13'h0002, 13'h0004}};
  always #2 i_clk = ~i_clk;
  // cycles spent polling, one counter for all tests
  always @(posedge i_clk) if (o_polling === 1'h1) poll_cyc <= poll_cyc + 1;
  dl_sched uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_start(i_start), .i_desc_addr(i_desc_addr),
    .o_busy(o_busy), .o_done(o_done), .o_polling(o_polling), .o_rd_req(o_rd_req),
    .o_rd_addr(o_rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_xfer_req(o_xfer_req), .o_xfer_addr(o_xfer_addr), .o_xfer_len(o_xfer_len),
    .i_xfer_done(xfer_done));
  host_mem host (.i_clk(i_clk), .i_rstn(i_rstn), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_xfer_req(o_xfer_req),
    .i_xfer_addr(o_xfer_addr), .i_xfer_len(o_xfer_len), .o_xfer_done(xfer_done));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'h1;
    @(posedge i_clk) i_reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk) i_reg_addr <= a;
    i_reg_rd <= 1'h1;
    @(posedge i_clk) i_reg_rd <= 1'h0;
    #1 d = o_reg_rdata;
  endtask
  task automatic go;
    @(posedge i_clk) i_start <= 1'h1;
    @(posedge i_clk) i_start <= 1'h0;
  endtask
  // bounded wait for packet end; a poll takes about 1000 cycles
  task automatic pkt;
    int k;
    k = 0;
    n0 = host.nx;
    s0 = host.sum;
    p0 = poll_cyc;
    go;
    while (o_done !== 1'h1 && k < 3000) begin
      @(posedge i_clk) k++;
      #1;
    end
    chk({31'h0, o_done}, 32'h1);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    // all tests need about 4500 cycles
    #40000;
    fails++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'h1;
    rd(`DLS_OFF_CTRL, v);
    chk(v, 32'h1);
    rd(`DLS_OFF_POLL, v);
    chk(v, 32'h4);
    rd(8'h20, v);
    chk(v, 32'h0);
    rd(`DLS_OFF_STAT, v);
    chk(v, 32'h0);
    rd(`DLS_OFF_RELT, v);
    chk(v, 32'h0);
    $display("test reset values done");
    // packets of two blocks; the driver side sets the final flag on the second
    foreach (rows[i]) begin
      host.mem[0] = rows[i].te;
      host.mem[1] = rows[i].fa;
      host.mem[2] = {19'h0, rows[i].l1};
      host.mem[3] = rows[i].fa + 32'h100;
      host.mem[4] = {1'h1, 18'h0, rows[i].l2};
      host.lat = (i % 2) * 2 + 1;
      wr(`DLS_OFF_TIME, {8'h0, rows[i].tw});
      pkt;
      chk(host.nx - n0, 32'h2);
      chk(host.sum - s0, rows[i].l1 + rows[i].l2);
      chk(host.last_a, rows[i].fa + 32'h100);
      chk({31'h0, poll_cyc != p0}, {31'h0, rows[i].pl});
      if (rows[i].te[28]) begin
        rd(`DLS_OFF_TIME, v);
        chk({16'h0, v[23:8]}, 32'h5);
      end
      if (rows[i].te[29]) begin
        rd(`DLS_OFF_RELT, v);
        chk(v, {8'h0, rows[i].te[23:0]});
      end
      $display("test row %0d done", i);
    end
    // counter rate: 2001 cycles hold 10 or 11 ticks of 200
    wr(`DLS_OFF_TIME, 32'h0);
    repeat (2000) @(posedge i_clk);
    rd(`DLS_OFF_TIME, v);
    chk({31'h0, v === 32'ha || v === 32'hb}, 32'h1);
    $display("test tick done");
    // a disabled engine ignores start
    wr(`DLS_OFF_CTRL, 32'h0);
    go;
    @(posedge i_clk) #1;
    chk({31'h0, o_busy}, 32'h0);
    $display("test disabled done");
    // alternate mode: first dword is already a block address; empty final block
    wr(`DLS_OFF_CTRL, 32'h3);
    host.mem[0] = 32'h40000007;
    host.mem[1] = 32'h00000009;
    host.mem[2] = 32'h60000003;
    host.mem[3] = 32'h80000000;
    pkt;
    chk(host.last_a, 32'h40000007);
    chk(host.nx - n0, 32'h1);
    chk(host.sum - s0, 32'h9);
    $display("test alternate done");
    // reset in mid packet returns to idle with reset values
    go;
    repeat (5) @(posedge i_clk);
    #1 chk({31'h0, o_busy}, 32'h1);
    i_rstn <= 1'h0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'h1;
    @(posedge i_clk) #1;
    chk({31'h0, o_busy}, 32'h0);
    rd(`DLS_OFF_CTRL, v);
    chk(v, 32'h1);
    rd(`DLS_OFF_TIME, v);
    chk(v, 32'h0);
    $display("test mid reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
